// ### design/ptm_timer.sv
// Protocol timer with auto start/stop, gating, reload and carrier prescaler behind APB.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module ptm_timer
    import ptm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_end,
    input wire logic field_on,
    input wire logic rx_bit,
    input wire logic carrier_in,
    input wire logic secure_signal_input,
    input wire logic auxiliary_pin_one,
    input wire logic address_pin_three,
    output logic running_flag,
    output logic timeout_irq_flag,
    output logic irq
);
    logic [7:0] timer_mode_config_q;
    logic [7:0] prescaler_low_byte_q;
    logic [15:0] reload_value_q;
    logic [3:0] config_q;
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] status_d;
    logic [IRQ_W-1:0] mask_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic running_q;
    logic running_d;
    logic [2:0] bits_q;
    logic [12:0] pre_q;
    logic field_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // Pin inputs pass two flip-flops; the carrier gets a third stage for its edge.
    // The carrier must stay below half of pclk, or edges are lost.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic carrier_old_q;
    wire [3:0] pins_raw = {carrier_in, address_pin_three, auxiliary_pin_one,
                           secure_signal_input};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            carrier_old_q <= 1'b0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            carrier_old_q <= sync2_q[3];
        end
    end
    wire carrier_edge = sync2_q[3] & ~carrier_old_q;

    // Bus decode.
    // Only byte lane zero carries data; misaligned or out-of-range addresses are refused.
    wire [5:0] idx = paddr[ADDR_W-1:IDX_LSB];
    wire aligned = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[31:ADDR_W] == 24'h0);
    wire hit_mode = aligned && idx == IDX_TIMER_MODE;
    wire hit_pre = aligned && idx == IDX_PRESCALE_LO;
    wire hit_rhi = aligned && idx == IDX_RELOAD_HI;
    wire hit_rlo = aligned && idx == IDX_RELOAD_LO;
    wire hit_chi = aligned && idx == IDX_COUNT_HI;
    wire hit_clo = aligned && idx == IDX_COUNT_LO;
    wire hit_ctl = aligned && idx == IDX_CONTROL;
    wire hit_cfg = aligned && idx == IDX_CONFIG;
    wire hit_sts = aligned && idx == IDX_IRQ_STATUS;
    wire hit_msk = aligned && idx == IDX_IRQ_MASK;
    wire hit_any = hit_mode | hit_pre | hit_rhi | hit_rlo | hit_chi | hit_clo
                 | hit_ctl | hit_cfg | hit_sts | hit_msk;
    wire access = psel & penable;
    // A write lands only at the edge where pready is sampled high.
    wire wr_en = access & pready_q & pwrite & pstrb[0];
    wire [7:0] wbyte = pwdata[7:0];
    wire [7:0] rd_byte =
        hit_mode ? timer_mode_config_q :
        hit_pre ? prescaler_low_byte_q :
        hit_rhi ? reload_value_q[15:8] :
        hit_rlo ? reload_value_q[7:0] :
        hit_chi ? count_q[15:8] :
        hit_clo ? count_q[7:0] :
        hit_cfg ? {4'h0, config_q} :
        hit_sts ? {6'h00, status_q} :
        hit_msk ? {6'h00, mask_q} : RST_BYTE;

    // Access phase lasts two cycles: pready rises in the second one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~hit_any;
            prdata_q <= (access & ~pready_q & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Register storage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_config_q <= RST_BYTE;
            prescaler_low_byte_q <= RST_BYTE;
            reload_value_q <= RST_COUNT;
            config_q <= 4'h0;
            mask_q <= 2'h0;
        end else if (wr_en) begin
            if (hit_mode) timer_mode_config_q <= wbyte;
            if (hit_pre) prescaler_low_byte_q <= wbyte;
            if (hit_rhi) reload_value_q[15:8] <= wbyte;
            if (hit_rlo) reload_value_q[7:0] <= wbyte;
            if (hit_cfg) config_q <= wbyte[3:0];
            if (hit_msk) mask_q <= wbyte[IRQ_W-1:0];
        end
    end

    // Mode fields.
    wire auto_start_enable = timer_mode_config_q[TM_AUTO_BIT];
    wire [1:0] gate_select = timer_mode_config_q[TM_GATE_HI:TM_GATE_LO];
    wire reload_on_zero = timer_mode_config_q[TM_RELOAD_BIT];
    wire [3:0] prescale_upper_nibble = timer_mode_config_q[TM_PRE_HI:0];
    wire [7:0] prescale_lower_byte = prescaler_low_byte_q;
    wire multi_frame_receive = config_q[CFG_MULTI_BIT];
    wire even_prescale_select = config_q[CFG_EVEN_BIT];
    wire initial_field_on = config_q[CFG_FIELD_BIT];
    wire five_bit_mode = config_q[CFG_FIVE_BIT];

    // Prescaler: counts carrier edges 0..2P (odd) or 0..2P+1 (even).
    wire [11:0] prescale_value = {prescale_upper_nibble, prescale_lower_byte};
    wire [12:0] pre_limit = {prescale_value, even_prescale_select};
    wire pre_wrap = pre_q >= pre_limit;
    wire tick = carrier_edge & pre_wrap;

    // Gate selection.
    // A closed gate holds the count; the running flag stays set.
    logic gate_open;
    always_comb begin
        unique case (ptm_gate_e'(gate_select))
            PTM_GATE_NONE: gate_open = 1'b1;
            PTM_GATE_SECURE: gate_open = sync2_q[0];
            PTM_GATE_AUXILIARY_PIN_ONE: gate_open = sync2_q[1];
            PTM_GATE_ADDR3: gate_open = sync2_q[2];
        endcase
    end

    // Start and stop events.
    wire field_rise = field_on & ~field_q;
    wire start_auto = auto_start_enable & (tx_end | (initial_field_on & field_rise));
    wire start_sw = wr_en & hit_ctl & wbyte[CTL_START_BIT];
    wire start_evt = start_auto | start_sw;
    wire stop_now_command = wr_en & hit_ctl & wbyte[CTL_STOP_BIT];
    wire [2:0] bits_limit = five_bit_mode ? BITS_STOP_FIVE : BITS_STOP_FOUR;
    wire auto_stop = auto_start_enable & ~multi_frame_receive & running_q & rx_bit
                   & (bits_q + 3'h1 == bits_limit);
    wire dec_en = running_q & tick & gate_open;
    wire at_zero = count_q == RST_COUNT;
    wire last_step = dec_en & (count_q <= 16'h0001) & ~reload_on_zero;

    // The prescaler rests at zero while stopped and restarts with every start.
    // A rate written between runs therefore takes effect cleanly from the next start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 13'h0000;
        end else if (start_evt || !running_q) begin
            pre_q <= 13'h0000;
        end else if (carrier_edge) begin
            pre_q <= pre_wrap ? 13'h0000 : pre_q + 13'h0001;
        end
    end

    // Later assignments win: a start overrides an auto-stop or zero, stop-now overrides all.
    always_comb begin
        running_d = running_q;
        count_d = count_q;
        if (dec_en) begin
            if (at_zero && reload_on_zero) begin
                count_d = reload_value_q;
            end else if (!at_zero) begin
                count_d = count_q - 16'h0001;
            end
            if (last_step) running_d = 1'b0;
        end
        if (auto_stop) running_d = 1'b0;
        if (start_evt) begin
            running_d = 1'b1;
            count_d = reload_value_q;
        end
        if (stop_now_command) running_d = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= 1'b0;
            count_q <= RST_COUNT;
            field_q <= 1'b0;
        end else begin
            running_q <= running_d;
            count_q <= count_d;
            field_q <= field_on;
        end
    end

    // Received bits are counted from each start.
    // The count saturates at its limit, so a long frame cannot wrap it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_q <= 3'h0;
        end else if (start_evt) begin
            bits_q <= 3'h0;
        end else if (running_q & rx_bit & (bits_q != bits_limit)) begin
            bits_q <= bits_q + 3'h1;
        end
    end

    // Interrupt status: a new event wins over a write-one clear.
    // The interrupt is built from the next status, so it rises on the flag's edge.
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_set = {auto_stop & ~start_evt, last_step};
    assign irq_clr = (wr_en & hit_sts) ? wbyte[IRQ_W-1:0] : 2'h0;
    assign status_d = (status_q & ~irq_clr) | irq_set;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign running_flag = running_q;
    assign timeout_irq_flag = status_q[IRQ_TIMEOUT];
    assign irq = irq_q;

    // Checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_auto_start_tx: assert property (
        tx_end && auto_start_enable && !stop_now_command |=> running_q && count_q == $past(reload_value_q))
        else $error("Auto start on end of transmission missed.");
    chk_field_start: assert property (
        auto_start_enable && initial_field_on && field_on && !$past(field_on) && !stop_now_command
        |=> running_q)
        else $error("Start on field switch-on missed.");
    chk_bit_stop: assert property (
        auto_stop && !start_evt |=> !running_q)
        else $error("Timer not stopped after received bits.");
    chk_multi_no_stop: assert property (
        running_q && multi_frame_receive && !stop_now_command && !last_step |=> running_q)
        else $error("Timer stopped during multi-frame receive.");
    chk_stop_now: assert property (
        stop_now_command |=> !running_q)
        else $error("Stop-now command ignored.");
    chk_manual_idle: assert property (
        !auto_start_enable && !running_q && !start_sw |=> !running_q)
        else $error("Timer started by protocol with auto start off.");
    chk_gate_hold: assert property (
        running_q && !gate_open && !start_evt |=> count_q == $past(count_q))
        else $error("Counter moved while gate closed.");
    chk_zero_stop: assert property (
        last_step && !start_evt |=> !running_q && status_q[IRQ_TIMEOUT] && count_q == RST_COUNT)
        else $error("Zero did not stop timer and flag timeout.");
    chk_reload_zero: assert property (
        dec_en && at_zero && reload_on_zero && !start_evt |=> running_q && count_q == $past(reload_value_q))
        else $error("Reload on zero failed.");
    chk_prescale_period: assert property (
        tick |-> pre_q == {prescale_value, even_prescale_select})
        else $error("Prescaler wrapped at the wrong count.");
    chk_bus_answer: assert property (
        access && !pready_q |=> pready_q ##1 !pready_q)
        else $error("Bus answer not one cycle wide.");

    // Bus answer checks.
    chk_error_ready: assert property (
        pslverr_q |-> pready_q)
        else $error("Bus error shown without ready.");
    chk_idle_rdata: assert property (
        !pready_q |-> prdata_q == 32'h0000_0000)
        else $error("Read data shown outside the answer cycle.");
    chk_ready_access: assert property (
        !access |=> !pready_q)
        else $error("Ready raised without an access.");
    chk_refused_write: assert property (
        wr_en && !hit_any |=> timer_mode_config_q == $past(timer_mode_config_q)
        && prescaler_low_byte_q == $past(prescaler_low_byte_q))
        else $error("Write to an unmapped address changed a register.");

    // Start and stop checks.
    chk_start_loads: assert property (
        start_evt && !stop_now_command |=> running_q && count_q == $past(reload_value_q))
        else $error("Start did not load the reload value.");
    chk_field_ignored: assert property (
        auto_start_enable && !initial_field_on && !running_q && !tx_end && !start_sw
        |=> !running_q)
        else $error("Field switch-on started the timer without its enable.");
    chk_four_bit_stop: assert property (
        auto_start_enable && !multi_frame_receive && !five_bit_mode && running_q && rx_bit
        && bits_q == BITS_STOP_FOUR - 3'h1 && !start_evt |=> !running_q)
        else $error("Timer not stopped after the fourth bit.");
    chk_five_bit_stop: assert property (
        auto_start_enable && !multi_frame_receive && five_bit_mode && running_q && rx_bit
        && bits_q == BITS_STOP_FIVE - 3'h1 && !start_evt |=> !running_q)
        else $error("Timer not stopped after the fifth bit.");
    chk_auto_off_keep: assert property (
        !auto_start_enable && running_q && !stop_now_command && !last_step |=> running_q)
        else $error("Protocol stopped the timer with auto start off.");
    chk_running_gated: assert property (
        running_q && !gate_open && !stop_now_command && !auto_stop |=> running_q)
        else $error("Running flag fell while the gate was closed.");

    // Counting and interrupt checks.
    chk_gate_none: assert property (
        ptm_gate_e'(gate_select) == PTM_GATE_NONE |-> gate_open)
        else $error("Ungated mode held the count.");
    chk_count_step: assert property (
        dec_en && !at_zero && !start_evt |=> count_q == $past(count_q) - 16'h0001)
        else $error("Counter did not step down by one on a tick.");
    chk_prescale_idle: assert property (
        !running_q && !$fell(running_q) |-> pre_q == 13'h0000)
        else $error("Prescaler moved while the timer was stopped.");
    chk_reload_no_flag: assert property (
        dec_en && reload_on_zero && !status_q[IRQ_TIMEOUT] |=> !status_q[IRQ_TIMEOUT])
        else $error("Timeout flag set in reload mode.");
    chk_flag_sticky: assert property (
        status_q[IRQ_TIMEOUT] && !(wr_en && hit_sts && wbyte[IRQ_TIMEOUT])
        |=> status_q[IRQ_TIMEOUT])
        else $error("Timeout flag cleared without a write of one.");
    chk_irq_level: assert property (
        irq_q == |(status_q & $past(mask_q)))
        else $error("Interrupt output does not follow unmasked status.");

    cov_auto_cycle: cover property (start_auto ##[1:200] auto_stop);
    cov_multi_frame: cover property (running_q && multi_frame_receive && rx_bit);
    cov_timeout: cover property (last_step);
    cov_reload: cover property (dec_en && at_zero && reload_on_zero);
    cov_gated: cover property (running_q && gate_select != 2'h0 && !gate_open);
endmodule : ptm_timer

// ### design/ptm_pkg.sv
// Package with register map, field positions and reset values of the protocol timer.
package ptm_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_TIMER_MODE = 6'h2A;
    localparam logic [5:0] IDX_PRESCALE_LO = 6'h2B;
    localparam logic [5:0] IDX_RELOAD_HI = 6'h2C;
    localparam logic [5:0] IDX_RELOAD_LO = 6'h2D;
    localparam logic [5:0] IDX_COUNT_HI = 6'h2E;
    localparam logic [5:0] IDX_COUNT_LO = 6'h2F;
    localparam logic [5:0] IDX_CONTROL = 6'h38;
    localparam logic [5:0] IDX_CONFIG = 6'h39;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h3A;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h3B;
    localparam int ADDR_W = 8;
    localparam int IDX_LSB = 2;

    // Fields of timer_mode_config.
    localparam int TM_AUTO_BIT = 7;
    localparam int TM_GATE_HI = 6;
    localparam int TM_GATE_LO = 5;
    localparam int TM_RELOAD_BIT = 4;
    localparam int TM_PRE_HI = 3;

    // Command bits of control_register; they read back as zero.
    localparam int CTL_STOP_BIT = 7;
    localparam int CTL_START_BIT = 6;

    // Fields of the configuration register.
    localparam int CFG_MULTI_BIT = 0;
    localparam int CFG_EVEN_BIT = 1;
    localparam int CFG_FIELD_BIT = 2;
    localparam int CFG_FIVE_BIT = 3;

    // Interrupt status and mask layout.
    localparam int IRQ_W = 2;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_AUTOSTOP = 1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [2:0] BITS_STOP_FIVE = 3'h5;
    localparam logic [2:0] BITS_STOP_FOUR = 3'h4;

    typedef enum logic [1:0] {
        PTM_GATE_NONE,
        PTM_GATE_SECURE,
        PTM_GATE_AUXILIARY_PIN_ONE,
        PTM_GATE_ADDR3
    } ptm_gate_e;
endpackage : ptm_pkg

// ### verif/ptm_timer_test.sv
// Self-checking testbench of the protocol timer with its register interface.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module ptm_timer_test import ptm_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic tx_end, field_on, rx_bit, carrier_in, running_flag, timeout_irq_flag, irq;
    logic [2:0] gp;
    logic [1:0] cdiv;
    logic [7:0] rdv;
    logic errv;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0;
    ptm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_end(tx_end), .field_on(field_on),
        .rx_bit(rx_bit), .carrier_in(carrier_in), .secure_signal_input(gp[0]),
        .auxiliary_pin_one(gp[1]), .address_pin_three(gp[2]), .running_flag(running_flag),
        .timeout_irq_flag(timeout_irq_flag), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // The carrier runs at a quarter of pclk, below the half rate the synchroniser needs.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        cdiv <= cdiv + 2'h1;
        if (cdiv[0]) carrier_in <= ~carrier_in;
    end
    task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) miscompares++;
        rdv = prdata[7:0];
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreg(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, {24'h000000, i, 2'h0}, d);
    endtask : wreg
    task automatic rreg(input logic [5:0] i);
        apb(1'b0, {24'h000000, i, 2'h0}, 8'h00);
    endtask : rreg
    task automatic setup(input logic [15:0] rl, input logic [7:0] md, input logic [7:0] cf);
        wreg(IDX_RELOAD_HI, rl[15:8]);
        wreg(IDX_RELOAD_LO, rl[7:0]);
        wreg(IDX_TIMER_MODE, md);
        wreg(IDX_CONFIG, cf);
    endtask : setup
    task automatic pulse(input logic is_rx);
        @(posedge pclk);
        if (is_rx) rx_bit <= 1'b1;
        else tx_end <= 1'b1;
        @(posedge pclk);
        tx_end <= 1'b0;
        rx_bit <= 1'b0;
        t0 = cyc;
    endtask : pulse
    task automatic wait_stop();
        int k;
        k = 0;
        @(posedge pclk);
        while (running_flag === 1'b1 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
    endtask : wait_stop
    task automatic halt();
        wreg(IDX_CONTROL, 8'h80);
        wreg(IDX_IRQ_STATUS, 8'h03);
    endtask : halt
    task automatic test_regs();
        rreg(IDX_TIMER_MODE);
        `CHK(rdv, RST_BYTE, "mode reset value")
        rreg(IDX_PRESCALE_LO);
        `CHK(rdv, RST_BYTE, "prescaler reset value")
        wreg(IDX_TIMER_MODE, 8'h5A);
        wreg(IDX_PRESCALE_LO, 8'hA5);
        rreg(IDX_TIMER_MODE);
        `CHK(rdv, 8'h5A, "mode readback")
        rreg(IDX_PRESCALE_LO);
        `CHK(rdv, 8'hA5, "prescaler readback")
        apb(1'b0, 32'h000000FC, 8'h00);
        `CHK(errv, 1'b1, "unmapped read not refused")
        wreg(IDX_TIMER_MODE, 8'h00);
        wreg(IDX_PRESCALE_LO, 8'h00);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_timeout();
        wreg(IDX_IRQ_MASK, 8'h00);
        setup(16'h0003, 8'h80, 8'h00);
        pulse(1'b0);
        @(posedge pclk);
        `CHK(running_flag, 1'b1, "no start at end of transmission")
        wreg(IDX_RELOAD_HI, 8'h01);
        wait_stop();
        `CHK(cyc - t0 < 40, 1'b1, "reload changed a running count")
        `CHK(timeout_irq_flag, 1'b1, "timeout flag not set")
        rreg(IDX_COUNT_LO);
        `CHK(rdv, 8'h00, "count not at zero")
        `CHK(irq, 1'b0, "masked interrupt raised")
        wreg(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1, "unmasked interrupt low")
        wreg(IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK({timeout_irq_flag, irq}, 2'b00, "status not cleared")
        $display("test_timeout done");
    endtask : test_timeout
    task automatic test_rate();
        int e;
        int x;
        for (e = 0; e < 2; e++) begin
            wreg(IDX_PRESCALE_LO, 8'h01);
            setup(16'h0004, 8'h80, e ? 8'h02 : 8'h00);
            pulse(1'b0);
            wait_stop();
            x = 16 * (3 + e);
            `CHK((cyc - t0 > x - 17) && (cyc - t0 < x + 7), 1'b1, "tick rate")
            halt();
        end
        $display("test_rate done");
    endtask : test_rate
    task automatic test_autostop();
        int m;
        int b;
        for (m = 0; m < 3; m++) begin
            b = (m == 1) ? 5 : 4;
            setup(16'h00FF, 8'h80, (m == 0) ? 8'h00 : ((m == 1) ? 8'h08 : 8'h09));
            pulse(1'b0);
            repeat (b - 1) pulse(1'b1);
            `CHK(running_flag, 1'b1, "stopped too early")
            pulse(1'b1);
            repeat (2) @(posedge pclk);
            `CHK(running_flag, m == 2, "stop on received bits")
            rreg(IDX_IRQ_STATUS);
            `CHK(rdv[IRQ_AUTOSTOP], m != 2, "auto-stop status")
            wreg(IDX_CONTROL, 8'h80);
            @(posedge pclk);
            `CHK(running_flag, 1'b0, "stop command ignored")
            halt();
        end
        $display("test_autostop done");
    endtask : test_autostop
    task automatic test_events();
        int f;
        for (f = 0; f < 3; f++) begin
            setup(16'h00FF, (f == 0) ? 8'h00 : 8'h80, (f == 1) ? 8'h00 : 8'h04);
            pulse(1'b0);
            @(posedge pclk);
            `CHK(running_flag, f != 0, "start on end of transmission")
            halt();
            field_on <= 1'b1;
            repeat (3) @(posedge pclk);
            `CHK(running_flag, f == 2, "start on field")
            field_on <= 1'b0;
            halt();
        end
        wreg(IDX_TIMER_MODE, 8'h00);
        wreg(IDX_CONTROL, 8'h40);
        repeat (5) pulse(1'b1);
        `CHK(running_flag, 1'b1, "protocol stop with auto off")
        halt();
        $display("test_events done");
    endtask : test_events
    task automatic test_gate();
        int g;
        wreg(IDX_PRESCALE_LO, 8'h00);
        for (g = 0; g < 4; g++) begin
            gp <= (g == 0) ? 3'h0 : ~(3'h1 << (g - 1));
            setup(16'h00FF, 8'h80 | 8'(g << 5), 8'h00);
            pulse(1'b0);
            repeat (40) @(posedge pclk);
            rreg(IDX_COUNT_LO);
            `CHK(rdv == 8'hFF, g != 0, "gate input choice")
            `CHK(running_flag, 1'b1, "running flag under closed gate")
            gp <= (g == 0) ? 3'h0 : 3'h1 << (g - 1);
            repeat (40) @(posedge pclk);
            rreg(IDX_COUNT_LO);
            `CHK(rdv < 8'hF8, 1'b1, "no count with gate open")
            halt();
        end
        gp <= 3'h0;
        $display("test_gate done");
    endtask : test_gate
    task automatic test_reload();
        setup(16'h0002, 8'h90, 8'h00);
        pulse(1'b0);
        repeat (60) @(posedge pclk);
        `CHK(running_flag, 1'b1, "count ended at zero")
        `CHK(timeout_irq_flag, 1'b0, "flag set with reload")
        rreg(IDX_COUNT_LO);
        `CHK(rdv <= 8'h02, 1'b1, "count above reload value")
        halt();
        $display("test_reload done");
    endtask : test_reload
    task automatic end_of_test();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // The tests need well under 10000 cycles; the watchdog allows twice that.
    initial begin
        #(8 * 20000);
        miscompares++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, tx_end, field_on, rx_bit, carrier_in} = 7'h00;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        gp = 3'h0;
        cdiv = 2'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_timeout();
        test_rate();
        test_autostop();
        test_events();
        test_gate();
        test_reload();
        end_of_test();
    end
endmodule : ptm_timer_test
